/* File: i2c_transaction_event_flags_tb.sv */
// Bench of the flag block and host agent joined over the link.
// Assumes the bench plays software on APB and the bus engine beside the block.
`timescale 1ns/1ps
module i2c_transaction_event_flags_tb;
    typedef struct packed {logic [3:0] ev; logic [31:0] sts; logic hold;} itef_row_t;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic pready_o, pslverr_o, irq_o;
    logic [31:0] prdata_o, cmd_data_o;
    logic [3:0] ev = 4'h0; // Write, read, controller done, target done.
    logic rd_busy_i = 1'b0;
    logic tx_empty_i = 1'b0;
    logic scl_hold_o, cmd_valid_o, tx_push_o, rx_pop_o;
    logic [7:0] tx_data_o;
    logic [7:0] tx_seen = 8'h00;
    int pushes = 0;
    int pops = 0;
    int failures = 0;
    int checks = 0;
    // Ordinary event cases: event, host irq status, clock stretched.
    itef_row_t rows [3] = '{'{4'b0010, 32'h1, 1'b1}, '{4'b0001, 32'h2, 1'b1}, '{4'b1000, 32'h4, 1'b0}};

    itef_link_if itef_link_if_i (.clk_i(clk_i));
    itef_device itef_device_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .link(itef_link_if_i),
        .ev_tgt_wr_i(ev[3]), .ev_tgt_rd_i(ev[2]), .ev_ctrl_done_i(ev[1]), .ev_tgt_done_i(ev[0]),
        .rd_busy_i(rd_busy_i), .tx_empty_i(tx_empty_i), .xfer_status_i(16'h1234), .rx_data_i(8'ha5),
        .scl_hold_o(scl_hold_o), .cmd_valid_o(cmd_valid_o), .cmd_data_o(cmd_data_o),
        .tx_push_o(tx_push_o), .tx_data_o(tx_data_o), .rx_pop_o(rx_pop_o));
    itef_host itef_host_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .link(itef_link_if_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
        .irq_o(irq_o));
    itef_checker itef_checker_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .req(itef_link_if_i.req),
        .wr(itef_link_if_i.wr), .addr(itef_link_if_i.addr), .wdata(itef_link_if_i.wdata),
        .ack(itef_link_if_i.ack), .rdata(itef_link_if_i.rdata), .irq(itef_link_if_i.irq));

    ////////////////////////////////////////
    // Shared tasks.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; waits for pready with no assumed latency.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        @(posedge clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 50);
        r = prdata_o;
        e = pslverr_o;
        chk(32'(pready_o), 32'h1);
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    // Reads a host register until the masked word matches, then compares it.
    task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] want);
        logic [31:0] r;
        logic e;
        int n;
        n = 0;
        do begin
            apb(1'b0, a, 32'h0, r, e);
            n++;
        end while ((r & m) !== want && n < 60);
        chk(r & m, want);
    endtask

    task automatic pulse(input logic [3:0] v);
        @(posedge clk_i);
        ev <= v;
        @(posedge clk_i);
        ev <= 4'h0;
    endtask

    // Waits for the host to feed the transmit side after a read request.
    task automatic wait_push();
        int n0;
        int n;
        n0 = pushes;
        n = 0;
        while (pushes == n0 && n < 200) begin
            @(posedge clk_i);
            n++;
        end
        chk(32'(pushes != n0), 32'h1);
        chk(32'(tx_seen), 32'h5a);
    endtask

    task automatic stop_test();
        if (failures == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////
    // Clock, watchdog and engine-side monitor.
    initial begin
        forever #2 clk_i = ~clk_i;
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        failures++;
        stop_test();
    end

    // Commands must never leave while a done flag holds the clock.
    always @(posedge clk_i) begin
        if (tx_push_o === 1'b1) begin
            pushes <= pushes + 1;
            tx_seen <= tx_data_o;
        end
        if (rx_pop_o === 1'b1)
            pops <= pops + 1;
        if (cmd_valid_o === 1'b1)
            chk(32'(scl_hold_o), 32'h0);
        if (itef_link_if_i.ack === 1'b1 && itef_link_if_i.wr === 1'b0 &&
            itef_link_if_i.addr === itef_pkg::RAW_IRQ_STATUS_IDX && itef_link_if_i.rdata[20:19] !== 2'h0)
            chk(32'(itef_link_if_i.rdata[18]), 32'h0);
    end

    ////////////////////////////////////////
    // Main sequence.
    initial begin
        logic [31:0] r;
        logic e;
        repeat (20) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        chk(32'({irq_o, scl_hold_o}), 32'h0);
        poll(itef_pkg::HOST_IRQ_ENABLE_ADDR, 32'hffffffff, 32'h0);
        apb(1'b0, 8'h1c, 32'h0, r, e);
        chk({r[30:0], e}, 32'h1);
        apb(1'b1, itef_pkg::HOST_IRQ_ENABLE_ADDR, 32'h7, r, e);
        apb(1'b1, itef_pkg::HOST_TX_DATA_ADDR, 32'h5a, r, e);
        poll(itef_pkg::HOST_TX_DATA_ADDR, 32'hffffffff, 32'h5a);
        foreach (rows[i]) begin
            pulse(rows[i].ev);
            #1;
            chk(32'(scl_hold_o), 32'(rows[i].hold));
            poll(itef_pkg::HOST_IRQ_STATUS_ADDR, 32'hffffffff, rows[i].sts);
            // The host clears the event's flag (done or write request) a few cycles after it posts the event.
            repeat (4) @(posedge clk_i);
            chk(32'({irq_o, scl_hold_o}), 32'h2);
            apb(1'b1, itef_pkg::HOST_IRQ_CLEAR_ADDR, rows[i].sts, r, e);
            poll(itef_pkg::HOST_IRQ_STATUS_ADDR, 32'hffffffff, 32'h0);
            chk(32'(irq_o), 32'h0);
        end
        // A masked event stays sticky but keeps the interrupt line low.
        apb(1'b1, itef_pkg::HOST_IRQ_ENABLE_ADDR, 32'h3, r, e);
        pulse(4'b1000);
        poll(itef_pkg::HOST_IRQ_STATUS_ADDR, 32'hffffffff, 32'h4);
        chk(32'(irq_o), 32'h0);
        apb(1'b1, itef_pkg::HOST_IRQ_CLEAR_ADDR, 32'h4, r, e);
        apb(1'b1, itef_pkg::HOST_IRQ_ENABLE_ADDR, 32'h7, r, e);
        // Target write and a command arrive while controller done is pending.
        pulse(4'b0010);
        pulse(4'b1000);
        #1;
        chk(32'(itef_device_i.st.wr_req), 32'h0);
        apb(1'b1, itef_pkg::HOST_CMD_ADDR, 32'h1, r, e);
        poll(itef_pkg::HOST_IRQ_STATUS_ADDR, 32'hffffffff, 32'h5);
        poll(itef_pkg::HOST_STATUS_ADDR, 32'h1ffff, 32'h1234);
        chk(cmd_data_o, 32'h1);
        apb(1'b1, itef_pkg::HOST_IRQ_CLEAR_ADDR, 32'h5, r, e);
        // The read command ends; its received byte is collected.
        pulse(4'b0010);
        poll(itef_pkg::HOST_IRQ_STATUS_ADDR, 32'hffffffff, 32'h1);
        poll(itef_pkg::HOST_RX_DATA_ADDR, 32'hff, 32'ha5);
        chk(32'(pops), 32'h1);
        apb(1'b1, itef_pkg::HOST_IRQ_CLEAR_ADDR, 32'h1, r, e);
        // Read request, then an empty transmit side in mid-read.
        pulse(4'b0100);
        wait_push();
        rd_busy_i <= 1'b1;
        tx_empty_i <= 1'b1;
        wait_push();
        @(posedge clk_i);
        rd_busy_i <= 1'b0;
        tx_empty_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk(32'(itef_link_if_i.irq), 32'h0);
        stop_test();
    end
endmodule // i2c_transaction_event_flags_tb

/* File: itef_checker.sv */
// Checker of the link between the host agent and the flag block.
// Assumes the bench instantiates it beside the link interface, no bind.
`timescale 1ns/1ps
module itef_checker (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Link signals.
    input wire logic req,
    input wire logic wr,
    input wire logic [2:0] addr,
    input wire logic [31:0] wdata,
    input wire logic ack,
    input wire logic [31:0] rdata,
    input wire logic irq
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);

    // A request is taken on the edge where req is up and ack still low.
    wire logic take = req && !ack;
    wire logic raw_rd = take && !wr && addr == itef_pkg::RAW_IRQ_STATUS_IDX;

    ////////////////////////////////////////
    // Handshake timing of the link.
    a_ack_latency: assert property (take |=> ack) else $error("ack late");
    a_ack_pulse: assert property (ack |=> !ack) else $error("ack longer than one cycle");
    a_ack_cause: assert property (ack |-> req && $past(req)) else $error("ack without request");
    a_req_release: assert property (ack |=> !req) else $error("req held past ack");
    a_req_hold: assert property (take |=> $stable(addr) && $stable(wr) && $stable(wdata))
        else $error("request changed before ack");
    // Read data only moves on a take, so software sees a steady word.
    a_rdata_hold: assert property (!take |=> $stable(rdata)) else $error("rdata moved");

    ////////////////////////////////////////
    // Content of the raw flag word.
    a_rsvd_zero: assert property (raw_rd |=> rdata[23:21] == 3'h0)
        else $error("reserved flag bits set");
    a_irq_flags: assert property (raw_rd |=> ((rdata[20:16] != 5'h00) == $past(irq)))
        else $error("irq disagrees with flags");

    // Main traffic kinds.
    c_raw_read: cover property (raw_rd);
    c_clear: cover property (take && wr && addr == itef_pkg::IRQ_CLEAR_IDX);
    c_command: cover property (take && wr && addr == itef_pkg::CTRL_COMMAND_IDX);
endmodule // itef_checker

/* File: itef_device.sv */
// Transaction event flag block of a two-wire controller/target: raw flags,
// clearing, clock stretching and command gating.
// Assumes a bus engine beside it that reports events as one-cycle pulses.
//
// Operation
// RL1: Read empty flag means TX empty during read.
// RL2: Target write address sets write request flag.
// RL3: Software may program DMA on write request.
// RL4: Controller done set after operation and stop.
// RL5: Software reads status, RX data, then clears.
// RL6: Next command accepted only after controller done cleared.
// RL7: Controller done pending stretches clock, defers requests.
// RL8: Target done set when target operation finishes.
// RL9: Software reads status, write data, then clears.
// RL10: Target done pending stretches clock, defers requests.
// RL11: Command accepted only after target done cleared.
// RL12: Flags clear only via clear register; 23:21 zero. The code also clears the read request flag on a TX data write.
// RL13: Read empty self-clears on TX write or end.
// RL14: Clear acts next cycle; simultaneous set wins.
`timescale 1ns/1ps
module itef_device (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Register link to the host.
    itef_link_if.device link,
    // Events from the bus engine.
    input wire logic ev_tgt_wr_i,
    input wire logic ev_tgt_rd_i,
    input wire logic ev_ctrl_done_i,
    input wire logic ev_tgt_done_i,
    input wire logic rd_busy_i,
    input wire logic tx_empty_i,
    input wire logic [15:0] xfer_status_i,
    input wire logic [7:0] rx_data_i,
    // Controls to the bus engine.
    output logic scl_hold_o,
    output logic cmd_valid_o,
    output logic [31:0] cmd_data_o,
    output logic tx_push_o,
    output logic [7:0] tx_data_o,
    output logic rx_pop_o
);

    ////////////////////////////////////////////////////////////////////////////
    // State.

    typedef struct packed {
        logic rd_req;
        logic rd_empty;
        logic wr_req;
        logic ctrl_done;
        logic tgt_done;
        logic pend_wr;
        logic pend_rd;
        logic cmd_reject;
        logic ack;
        logic [31:0] rdata;
        logic cmd_valid;
        logic [31:0] cmd_data;
        logic tx_push;
        logic [7:0] tx_data;
        logic rx_pop;
    } itef_dev_state_t;

    itef_dev_state_t st;
    itef_dev_state_t next_st;

    logic take;
    logic blocked;
    logic [31:0] raw;
    logic [31:0] clr;

    ////////////////////////////////////////////////////////////////////////////
    // Next state.

    // A request is taken once, in the cycle before ack rises.
    always_comb begin
        next_st = st;
        take = link.req && !st.ack;
        clr = (take && link.wr && link.addr == itef_pkg::IRQ_CLEAR_IDX) ? link.wdata : 32'h0000_0000;
        // Either done flag left standing holds the bus and gates new work.
        blocked = st.ctrl_done || st.tgt_done; // [RL7] [RL10]
        raw = 32'h0000_0000;
        raw[itef_pkg::TGT_RD_REQ_BIT] = st.rd_req;
        raw[itef_pkg::TGT_RD_EMPTY_BIT] = st.rd_empty;
        raw[itef_pkg::TGT_WR_REQ_BIT] = st.wr_req;
        raw[itef_pkg::CTRL_DONE_BIT] = st.ctrl_done;
        raw[itef_pkg::TGT_DONE_BIT] = st.tgt_done; // bits 23:21 stay zero [RL12]
        next_st.ack = take;
        next_st.cmd_valid = 1'b0;
        next_st.tx_push = 1'b0;
        next_st.rx_pop = 1'b0;

        // Register accesses.
        if (take) begin
            next_st.rdata = 32'h0000_0000;
            if (link.wr) begin
                unique case (link.addr)
                    itef_pkg::CTRL_COMMAND_IDX: begin
                        // A command while a done flag stands is dropped and noted.
                        if (blocked) begin // [RL6] [RL11]
                            next_st.cmd_reject = 1'b1;
                        end else begin
                            next_st.cmd_reject = 1'b0;
                            next_st.cmd_valid = 1'b1;
                            next_st.cmd_data = link.wdata;
                        end
                    end
                    itef_pkg::TX_DATA_IDX: begin
                        next_st.tx_push = 1'b1;
                        next_st.tx_data = link.wdata[7:0];
                    end
                    default: begin
                    end
                endcase
            end else begin
                unique case (link.addr)
                    itef_pkg::RAW_IRQ_STATUS_IDX: next_st.rdata = raw;
                    itef_pkg::XFER_STATUS_IDX: begin
                        next_st.rdata[15:0] = xfer_status_i;
                        next_st.rdata[itef_pkg::CMD_REJECT_BIT] = st.cmd_reject;
                    end
                    itef_pkg::RX_DATA_IDX: begin
                        next_st.rdata[7:0] = rx_data_i;
                        next_st.rx_pop = 1'b1;
                    end
                    default: begin
                    end
                endcase
            end
        end

        // Clears act on the next edge; any set below overrides them.
        if (clr[itef_pkg::TGT_RD_REQ_BIT]) begin // [RL12] [RL14]
            next_st.rd_req = 1'b0;
        end
        if (clr[itef_pkg::TGT_WR_REQ_BIT]) begin // [RL12] [RL14]
            next_st.wr_req = 1'b0;
        end
        if (clr[itef_pkg::CTRL_DONE_BIT]) begin // [RL12] [RL14]
            next_st.ctrl_done = 1'b0;
        end
        if (clr[itef_pkg::TGT_DONE_BIT]) begin // [RL12] [RL14]
            next_st.tgt_done = 1'b0;
        end
        // Writing TX data serves a read request.
        if (next_st.tx_push) begin
            next_st.rd_req = 1'b0;
        end

        // Target addressing is held back while a done flag stands, so
        // software never sees a new request before acknowledging the last.
        if (ev_tgt_wr_i) begin
            next_st.pend_wr = 1'b1;
        end
        if (ev_tgt_rd_i) begin
            next_st.pend_rd = 1'b1;
        end
        if ((ev_tgt_wr_i || st.pend_wr) && !blocked) begin // [RL7] [RL10]
            next_st.wr_req = 1'b1; // [RL2]
            next_st.pend_wr = 1'b0;
        end
        if ((ev_tgt_rd_i || st.pend_rd) && !blocked) begin // [RL7] [RL10]
            next_st.rd_req = 1'b1;
            next_st.pend_rd = 1'b0;
        end
        if (ev_ctrl_done_i) begin
            next_st.ctrl_done = 1'b1; // [RL4]
        end
        if (ev_tgt_done_i) begin
            next_st.tgt_done = 1'b1; // [RL8]
        end

        // Empty flag follows the read and the FIFO, dropping on a push.
        next_st.rd_empty = rd_busy_i && tx_empty_i && !next_st.tx_push; // [RL1] [RL13]
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers.

    // Synchronous reset brings every flag to zero.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st <= '0;
            st.rd_req <= itef_pkg::FLAGS_RESET[0];
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.

    // Clock line is held low as long as a done flag waits for software.
    assign scl_hold_o = st.ctrl_done || st.tgt_done; // [RL7] [RL10]
    assign link.ack = st.ack;
    assign link.rdata = st.rdata;
    assign link.irq = st.rd_req || st.rd_empty || st.wr_req || st.ctrl_done || st.tgt_done;
    assign cmd_valid_o = st.cmd_valid;
    assign cmd_data_o = st.cmd_data;
    assign tx_push_o = st.tx_push;
    assign tx_data_o = st.tx_data;
    assign rx_pop_o = st.rx_pop;

endmodule // itef_device

/* File: itef_host.sv */
// Host agent: serves the flag block for software and holds APB registers.
// Assumes the device answers each link request with a one-cycle ack.
//
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
module itef_host (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Link to the flag block.
    itef_link_if.host link,
    // APB slave.
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic pready_o,
    output logic [31:0] prdata_o,
    output logic pslverr_o,
    // Interrupt.
    output logic irq_o
);

    ////////////////////////////////////////////////////////////////////////////
    // State.

    typedef enum {
        IDLE, RD_RAW, CHECK, RD_STAT, RD_RX, WR_CLR, WR_TX, WR_CMD
    } itef_host_fsm_t;

    typedef struct packed {
        itef_host_fsm_t fsm;
        logic req;
        logic wr;
        logic [2:0] addr;
        logic [31:0] wdata;
        logic [31:0] raw;
        logic [31:0] clr_val;
        logic need_rx;
        logic last_read;
        logic tgt_write;
        logic cmd_pend;
        logic [31:0] cmd;
        logic [15:0] stat;
        logic [7:0] rx;
        logic [7:0] tx;
        logic [2:0] irq_sts;
        logic [2:0] irq_en;
        logic apb_ack;
        logic apb_err;
        logic [31:0] prdata;
    } itef_host_state_t;

    itef_host_state_t st;
    itef_host_state_t next_st;
    logic [2:0] ev;
    logic apb_take;

    ////////////////////////////////////////////////////////////////////////////
    // Next state.

    always_comb begin
        next_st = st;
        ev = 3'h0;
        apb_take = psel_i && penable_i && !st.apb_ack;
        next_st.apb_ack = apb_take;
        next_st.apb_err = 1'b0;

        // Link sequencer; an access is launched only while req is low.
        if (st.req) begin
            if (link.ack) begin
                next_st.req = 1'b0;
                unique case (st.fsm)
                    RD_RAW: begin
                        next_st.raw = link.rdata;
                        next_st.fsm = CHECK;
                    end
                    RD_STAT: begin
                        next_st.stat = link.rdata[15:0];
                        next_st.fsm = st.need_rx ? RD_RX : WR_CLR;
                    end
                    RD_RX: begin
                        next_st.rx = link.rdata[7:0];
                        next_st.fsm = WR_CLR;
                    end
                    WR_CMD: begin
                        next_st.cmd_pend = 1'b0;
                        next_st.fsm = IDLE;
                    end
                    default: next_st.fsm = IDLE;
                endcase
            end
        end else begin
            unique case (st.fsm)
                IDLE: begin
                    if (link.irq || st.cmd_pend) begin
                        next_st.fsm = RD_RAW;
                        next_st.req = 1'b1;
                        next_st.wr = 1'b0;
                        next_st.addr = itef_pkg::RAW_IRQ_STATUS_IDX;
                    end
                end
                CHECK: begin
                    next_st.req = 1'b1;
                    next_st.wr = 1'b0;
                    next_st.addr = itef_pkg::XFER_STATUS_IDX;
                    next_st.clr_val = 32'h0000_0000;
                    // Controller done: status, RX data for a read, then clear.
                    if (st.raw[itef_pkg::CTRL_DONE_BIT]) begin // [RL5]
                        next_st.fsm = RD_STAT;
                        next_st.need_rx = st.last_read;
                        next_st.clr_val[itef_pkg::CTRL_DONE_BIT] = 1'b1;
                        ev[0] = 1'b1;
                    end else if (st.raw[itef_pkg::TGT_DONE_BIT]) begin // [RL9]
                        next_st.fsm = RD_STAT;
                        next_st.need_rx = st.tgt_write;
                        next_st.tgt_write = 1'b0;
                        next_st.clr_val[itef_pkg::TGT_DONE_BIT] = 1'b1;
                        ev[1] = 1'b1;
                    end else if (st.raw[itef_pkg::TGT_WR_REQ_BIT]) begin
                        // A DMA set-up would hook in here; the agent just clears.
                        next_st.fsm = WR_CLR; // [RL3]
                        next_st.req = 1'b0;
                        next_st.tgt_write = 1'b1;
                        next_st.clr_val[itef_pkg::TGT_WR_REQ_BIT] = 1'b1;
                        ev[2] = 1'b1;
                    end else if (st.raw[itef_pkg::TGT_RD_REQ_BIT] || st.raw[itef_pkg::TGT_RD_EMPTY_BIT]) begin
                        next_st.fsm = WR_TX;
                        next_st.wr = 1'b1;
                        next_st.addr = itef_pkg::TX_DATA_IDX;
                        next_st.wdata = {24'h00_0000, st.tx};
                    end else if (st.cmd_pend) begin
                        // Both done flags seen clear, so the command may go.
                        next_st.fsm = WR_CMD; // [RL6] [RL11]
                        next_st.wr = 1'b1;
                        next_st.addr = itef_pkg::CTRL_COMMAND_IDX;
                        next_st.wdata = st.cmd;
                        next_st.last_read = st.cmd[itef_pkg::CMD_READ_BIT];
                    end else begin
                        next_st.fsm = IDLE;
                        next_st.req = 1'b0;
                    end
                end
                RD_RX: begin
                    next_st.req = 1'b1;
                    next_st.wr = 1'b0;
                    next_st.addr = itef_pkg::RX_DATA_IDX;
                end
                WR_CLR: begin
                    next_st.req = 1'b1;
                    next_st.wr = 1'b1;
                    next_st.addr = itef_pkg::IRQ_CLEAR_IDX;
                    next_st.wdata = st.clr_val;
                end
                default: next_st.req = 1'b1;
            endcase
        end

        // APB register file, answered one cycle into the access phase.
        if (apb_take) begin
            next_st.prdata = 32'h0000_0000;
            unique case (paddr_i)
                itef_pkg::HOST_CMD_ADDR: begin
                    if (pwrite_i) begin
                        next_st.cmd = pwdata_i;
                        next_st.cmd_pend = 1'b1;
                    end
                end
                itef_pkg::HOST_STATUS_ADDR: next_st.prdata = {15'h0000, st.cmd_pend, st.stat};
                itef_pkg::HOST_IRQ_STATUS_ADDR: next_st.prdata = {29'h0000_0000, st.irq_sts};
                itef_pkg::HOST_IRQ_CLEAR_ADDR: begin
                    if (pwrite_i) begin
                        next_st.irq_sts = st.irq_sts & ~pwdata_i[2:0];
                    end
                end
                itef_pkg::HOST_IRQ_ENABLE_ADDR: begin
                    if (pwrite_i) begin
                        next_st.irq_en = pwdata_i[2:0];
                    end
                    next_st.prdata = {29'h0000_0000, st.irq_en};
                end
                itef_pkg::HOST_RX_DATA_ADDR: next_st.prdata = {24'h00_0000, st.rx};
                itef_pkg::HOST_TX_DATA_ADDR: begin
                    if (pwrite_i) begin
                        next_st.tx = pwdata_i[7:0];
                    end
                    next_st.prdata = {24'h00_0000, st.tx};
                end
                default: next_st.apb_err = 1'b1;
            endcase
        end
        // Events are applied after the clear so that a new one is kept.
        next_st.irq_sts = next_st.irq_sts | ev;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers.

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st <= '0;
            st.fsm <= IDLE;
            st.irq_sts <= itef_pkg::HOST_IRQ_RESET;
        end else begin
            st <= next_st;
        end
    end

    // Outputs.
    assign link.req = st.req;
    assign link.wr = st.wr;
    assign link.addr = st.addr;
    assign link.wdata = st.wdata;
    assign pready_o = st.apb_ack;
    assign prdata_o = st.prdata;
    assign pslverr_o = st.apb_err;
    assign irq_o = |(st.irq_sts & st.irq_en);

endmodule // itef_host

/* File: itef_link_if.sv */
// Interface joining the host agent to the flag block register port.
// Assumes one clock shared by both ends; no clocking block.
`timescale 1ns/1ps
interface itef_link_if (
    input wire logic clk_i
);
    logic req;
    logic wr;
    logic [2:0] addr;
    logic [31:0] wdata;
    logic ack;
    logic [31:0] rdata;
    logic irq;

    modport device (input req, wr, addr, wdata, output ack, rdata, irq);
    modport host (output req, wr, addr, wdata, input ack, rdata, irq);
endinterface

/* File: itef_pkg.sv */
// Package of the transaction event flag block: offsets, flag positions and
// host register map. Both ends and the bench refer to it by package::name.
package itef_pkg;

    // Device register indexes on the link between the two ends.
    localparam logic [2:0] RAW_IRQ_STATUS_IDX = 3'h0;
    localparam logic [2:0] IRQ_CLEAR_IDX = 3'h1;
    localparam logic [2:0] CTRL_COMMAND_IDX = 3'h2;
    localparam logic [2:0] XFER_STATUS_IDX = 3'h3;
    localparam logic [2:0] TX_DATA_IDX = 3'h4;
    localparam logic [2:0] RX_DATA_IDX = 3'h5;

    // Flag positions in the raw status, clear, transfer status and command registers, and the flag reset value.
    localparam int TGT_RD_REQ_BIT = 16;
    localparam int TGT_RD_EMPTY_BIT = 17;
    localparam int TGT_WR_REQ_BIT = 18;
    localparam int CTRL_DONE_BIT = 19;
    localparam int TGT_DONE_BIT = 20;
    localparam int CMD_REJECT_BIT = 16;
    localparam int CMD_READ_BIT = 0;
    localparam logic [4:0] FLAGS_RESET = 5'h00;

    // Host APB map, byte addresses.
    localparam logic [7:0] HOST_CMD_ADDR = 8'h00;
    localparam logic [7:0] HOST_STATUS_ADDR = 8'h04;
    localparam logic [7:0] HOST_IRQ_STATUS_ADDR = 8'h08;
    localparam logic [7:0] HOST_IRQ_CLEAR_ADDR = 8'h0c;
    localparam logic [7:0] HOST_IRQ_ENABLE_ADDR = 8'h10;
    localparam logic [7:0] HOST_RX_DATA_ADDR = 8'h14;
    localparam logic [7:0] HOST_TX_DATA_ADDR = 8'h18;
    localparam logic [2:0] HOST_IRQ_RESET = 3'h0;

endpackage
